// File: shared/fire_pkg.sv
package fire_pkg;
    // ------------------------------------------------------------
    // Register map (word byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] BURST_ADDR = 4'h4;
    localparam logic [3:0] PHASE_ADDR = 4'h8;
    localparam logic [3:0] CMD_ADDR = 4'hC;
    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int CTRL_DOWN_BIT = 0;
    localparam int CTRL_BOTH_BIT = 1;
    localparam int CTRL_INT_START_BIT = 2;
    localparam int CTRL_IDLE_LOW_BIT = 3;
    localparam int CTRL_MAINS_BIT = 4;
    localparam int CTRL_PAUSE_LSB = 8;
    localparam int CTRL_PAUSE_W = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // ------------------------------------------------------------
    // Burst fields
    // ------------------------------------------------------------
    localparam int BURST_COUNT_LSB = 0;
    localparam int BURST_COUNT_W = 7;
    localparam int BURST_DIV_LSB = 8;
    localparam int BURST_DIV_W = 4;
    localparam int BURST_REP_LSB = 16;
    localparam int BURST_REP_W = 8;
    localparam logic [31:0] BURST_RESET = 32'h0001_0101;
    localparam logic [31:0] PHASE_RESET = 32'h0000_0000;
    localparam int PHASE_W = 16;
    // ------------------------------------------------------------
    // Command / status fields
    // ------------------------------------------------------------
    localparam int CMD_SINGLE_BIT = 0;
    localparam int CMD_PAIR_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_UP_ACTIVE_BIT = 1;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int BASE50_US = 20_000;
    localparam int BASE60_US = 16_670;
    localparam int BASE50_CYC = (CLK_HZ / 1000) * BASE50_US / 1000;
    localparam int BASE60_CYC = (CLK_HZ / 1000) * BASE60_US / 1000;
endpackage

// File: rtl/fire_sync.sv
module fire_sync (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic d_in,
    output logic q_out
);
    logic stage1;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stage1 <= 1'b0;
            q_out <= 1'b0;
        end else begin
            stage1 <= d_in;
            q_out <= stage1;
        end
    end
endmodule // fire_sync

// File: rtl/fire_burst.sv
module fire_burst #(
    parameter int COUNT_W = 7,
    parameter int DIV_W = 4,
    parameter int REP_W = 8,
    parameter int PHASE_W = 16
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic go_in,
    input wire logic [COUNT_W-1:0] count_in,
    input wire logic [DIV_W-1:0] div_in,
    input wire logic [REP_W-1:0] rep_in,
    input wire logic [PHASE_W-1:0] phase_in,
    output logic active_out,
    output logic wave_out,
    output logic done_out
);
    logic [DIV_W-1:0] div_cnt;
    logic half;
    logic [COUNT_W-1:0] pulse;
    logic [REP_W-1:0] rep;
    logic cur_phase;
    // ------------------------------------------------------------
    // Pulse sequencing
    // ------------------------------------------------------------
    always_comb begin
        cur_phase = (pulse < COUNT_W'(PHASE_W)) ? phase_in[pulse[3:0]] : 1'b1;
    end
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            active_out <= 1'b0;
            wave_out <= 1'b0;
            done_out <= 1'b0;
            div_cnt <= '0;
            half <= 1'b0;
            pulse <= '0;
            rep <= '0;
        end else begin
            done_out <= 1'b0;
            if (!active_out) begin
                if (go_in) begin
                    active_out <= 1'b1;
                    div_cnt <= '0;
                    half <= 1'b0;
                    pulse <= '0;
                    rep <= '0;
                    wave_out <= ~phase_in[0];
                end
            end else if (div_cnt == div_in) begin
                div_cnt <= '0;
                if (!half) begin
                    half <= 1'b1;
                    wave_out <= cur_phase;
                end else begin
                    half <= 1'b0;
                    if (pulse + 1'b1 >=
                        ((count_in == '0) ? COUNT_W'(1) : count_in)) begin
                        pulse <= '0;
                        if (rep + 1'b1 >=
                            ((rep_in == '0) ? REP_W'(1) : rep_in)) begin
                            active_out <= 1'b0;
                            done_out <= 1'b1;
                            wave_out <= 1'b0;
                        end else begin
                            rep <= rep + 1'b1;
                            wave_out <= ~phase_in[0];
                        end
                    end else begin
                        pulse <= pulse + 1'b1;
                        wave_out <= ~((pulse + 1'b1 < COUNT_W'(PHASE_W)) ?
                            phase_in[4'(pulse + 1'b1)] : 1'b1);
                    end
                end
            end else begin
                div_cnt <= div_cnt + 1'b1;
            end
        end
    end
endmodule // fire_burst

// File: rtl/fire_top.sv
module fire_top #(
    parameter int BASE50_CYCLES = fire_pkg::BASE50_CYC,
    parameter int BASE60_CYCLES = fire_pkg::BASE60_CYC
) (
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    input wire logic [3:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    input wire logic EXT_START_IN,
    output logic FIRE_UP_OUT,
    output logic FIRE_UP_OE_N_OUT,
    output logic FIRE_DOWN_OUT,
    output logic FIRE_DOWN_OE_N_OUT,
    output logic MEAS_START_OUT,
    output logic UP_ACTIVE_OUT
);
    typedef enum logic [2:0] {
        S_IDLE, S_FIRST, S_PAUSE, S_SECOND
    } seq_e;
    seq_e state;
    logic [31:0] ctrl;
    logic [31:0] burst;
    logic [31:0] phase;
    logic pending_single;
    logic pending_pair;
    logic ack;
    logic go;
    logic active;
    logic wave;
    logic done;
    logic ext_sync;
    logic ext_prev;
    logic dir_down;
    logic [31:0] base_cnt;
    logic [7:0] pause_cnt;
    logic pair_mode;
    logic write_strobe;
    logic down_select;
    logic both_select;
    logic internal_start_select;
    logic idle_drive_low_select;
    logic mains_base_select;
    logic [fire_pkg::CTRL_PAUSE_W-1:0] direction_pause_count;
    logic [fire_pkg::BURST_COUNT_W-1:0] burst_pulse_count;
    logic bidirectional_flight_command;
    logic [31:0] base_period;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    always_comb begin
        write_strobe = AVS_WRITE_IN & ~AVS_WAITREQUEST_OUT;
        down_select = ctrl[fire_pkg::CTRL_DOWN_BIT];
        both_select = ctrl[fire_pkg::CTRL_BOTH_BIT];
        internal_start_select = ctrl[fire_pkg::CTRL_INT_START_BIT];
        idle_drive_low_select = ctrl[fire_pkg::CTRL_IDLE_LOW_BIT];
        mains_base_select = ctrl[fire_pkg::CTRL_MAINS_BIT];
        direction_pause_count = ctrl[fire_pkg::CTRL_PAUSE_LSB +:
                                     fire_pkg::CTRL_PAUSE_W];
        burst_pulse_count = burst[fire_pkg::BURST_COUNT_LSB +:
                                  fire_pkg::BURST_COUNT_W];
        bidirectional_flight_command = write_strobe &&
            AVS_ADDRESS_IN == fire_pkg::CMD_ADDR && AVS_BYTEENABLE_IN[0] &&
            AVS_WRITEDATA_IN[fire_pkg::CMD_PAIR_BIT];
        base_period = mains_base_select ? 32'(BASE60_CYCLES) :
                      32'(BASE50_CYCLES);
    end

    // ------------------------------------------------------------
    // Avalon slave: one wait cycle, answer on the second
    // ------------------------------------------------------------
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            ack <= 1'b0;
            AVS_WAITREQUEST_OUT <= 1'b1;
        end else begin
            ack <= (AVS_READ_IN | AVS_WRITE_IN) & ~ack;
            AVS_WAITREQUEST_OUT <= ~((AVS_READ_IN | AVS_WRITE_IN) & ~ack);
        end
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            ctrl <= fire_pkg::CTRL_RESET;
        end else if (write_strobe &&
                     AVS_ADDRESS_IN == fire_pkg::CTRL_ADDR) begin
            ctrl <= merge(ctrl, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
        end
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            burst <= fire_pkg::BURST_RESET;
        end else if (write_strobe &&
                     AVS_ADDRESS_IN == fire_pkg::BURST_ADDR) begin
            burst <= merge(burst, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
        end
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            phase <= fire_pkg::PHASE_RESET;
        end else if (write_strobe &&
                     AVS_ADDRESS_IN == fire_pkg::PHASE_ADDR) begin
            phase <= merge(phase, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
        end
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            AVS_READDATA_OUT <= '0;
        end else if (AVS_READ_IN && !ack) begin
            case (AVS_ADDRESS_IN)
                fire_pkg::CTRL_ADDR: AVS_READDATA_OUT <= ctrl;
                fire_pkg::BURST_ADDR: AVS_READDATA_OUT <= burst;
                fire_pkg::PHASE_ADDR: AVS_READDATA_OUT <= phase;
                fire_pkg::CMD_ADDR: AVS_READDATA_OUT <= {30'h0,
                    UP_ACTIVE_OUT, state != S_IDLE};
                default: AVS_READDATA_OUT <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Command capture
    // ------------------------------------------------------------
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            pending_single <= 1'b0;
            pending_pair <= 1'b0;
        end else begin
            if (write_strobe && AVS_ADDRESS_IN == fire_pkg::CMD_ADDR &&
                AVS_BYTEENABLE_IN[0]) begin
                if (AVS_WRITEDATA_IN[fire_pkg::CMD_SINGLE_BIT]) begin
                    pending_single <= 1'b1;
                end
                if (bidirectional_flight_command) begin
                    pending_pair <= 1'b1;
                end
            end else if (state == S_IDLE) begin
                pending_single <= 1'b0;
                pending_pair <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            state <= S_IDLE;
            go <= 1'b0;
            dir_down <= 1'b0;
            pair_mode <= 1'b0;
            base_cnt <= '0;
            pause_cnt <= '0;
        end else begin
            go <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (pending_pair || pending_single) begin
                        dir_down <= down_select;
                        pair_mode <= pending_pair;
                        go <= 1'b1;
                        state <= S_FIRST;
                    end
                end
                S_FIRST: begin
                    if (done) begin
                        if (pair_mode) begin
                            base_cnt <= '0;
                            pause_cnt <= '0;
                            state <= S_PAUSE;
                        end else begin
                            state <= S_IDLE;
                        end
                    end
                end
                S_PAUSE: begin
                    if (pause_cnt >= direction_pause_count) begin
                        dir_down <= ~dir_down;
                        go <= 1'b1;
                        state <= S_SECOND;
                    end else if (base_cnt + 32'h0000_0001 >=
                                 base_period) begin
                        base_cnt <= '0;
                        pause_cnt <= pause_cnt + 8'h01;
                    end else begin
                        base_cnt <= base_cnt + 32'h0000_0001;
                    end
                end
                S_SECOND: begin
                    if (done) begin
                        state <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    fire_burst #(
        .COUNT_W(fire_pkg::BURST_COUNT_W),
        .DIV_W(fire_pkg::BURST_DIV_W),
        .REP_W(fire_pkg::BURST_REP_W),
        .PHASE_W(fire_pkg::PHASE_W)
    ) u_burst (
        .clk_in(CLK_IN),
        .nrst_in(NRST_IN),
        .go_in(go),
        .count_in(burst_pulse_count),
        .div_in(burst[fire_pkg::BURST_DIV_LSB +: fire_pkg::BURST_DIV_W]),
        .rep_in(burst[fire_pkg::BURST_REP_LSB +: fire_pkg::BURST_REP_W]),
        .phase_in(phase[fire_pkg::PHASE_W-1:0]),
        .active_out(active),
        .wave_out(wave),
        .done_out(done)
    );

    fire_sync u_ext (
        .clk_in(CLK_IN),
        .nrst_in(NRST_IN),
        .d_in(EXT_START_IN),
        .q_out(ext_sync)
    );

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            FIRE_UP_OUT <= 1'b0;
            FIRE_UP_OE_N_OUT <= 1'b1;
            FIRE_DOWN_OUT <= 1'b0;
            FIRE_DOWN_OE_N_OUT <= 1'b1;
            UP_ACTIVE_OUT <= 1'b0;
        end else begin
            UP_ACTIVE_OUT <= active & ~dir_down;
            if (active && both_select) begin
                FIRE_UP_OUT <= wave;
                FIRE_UP_OE_N_OUT <= 1'b0;
                FIRE_DOWN_OUT <= ~wave;
                FIRE_DOWN_OE_N_OUT <= 1'b0;
            end else begin
                FIRE_UP_OUT <= active & ~dir_down & wave;
                FIRE_UP_OE_N_OUT <= ~((active & ~dir_down) |
                    idle_drive_low_select);
                FIRE_DOWN_OUT <= active & dir_down & wave;
                FIRE_DOWN_OE_N_OUT <= ~((active & dir_down) |
                    idle_drive_low_select);
            end
        end
    end

    // ------------------------------------------------------------
    // Measurement start
    // ------------------------------------------------------------
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            ext_prev <= 1'b0;
            MEAS_START_OUT <= 1'b0;
        end else begin
            ext_prev <= ext_sync;
            if (internal_start_select) begin
                MEAS_START_OUT <= go;
            end else begin
                MEAS_START_OUT <= ext_sync & ~ext_prev;
            end
        end
    end
endmodule // fire_top

// File: testbench/fire_monitor.sv
module fire_monitor (
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    input wire logic [3:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    input wire logic AVS_WAITREQUEST_OUT,
    input wire logic FIRE_UP_OUT,
    input wire logic FIRE_UP_OE_N_OUT,
    input wire logic FIRE_DOWN_OUT,
    input wire logic FIRE_DOWN_OE_N_OUT,
    input wire logic MEAS_START_OUT,
    input wire logic UP_ACTIVE_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Shadow of control and divider fields
    // ----------------------------------------
    logic [7:0] ctrl;
    logic [3:0] dv;
    logic up_q;
    int gap;
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            ctrl <= 8'h00;
            dv <= 4'h1;
        end else if (AVS_WRITE_IN && !AVS_WAITREQUEST_OUT) begin
            if (AVS_ADDRESS_IN == fire_pkg::CTRL_ADDR && AVS_BYTEENABLE_IN[0]) begin
                ctrl <= AVS_WRITEDATA_IN[7:0];
            end
            if (AVS_ADDRESS_IN == fire_pkg::BURST_ADDR && AVS_BYTEENABLE_IN[1]) begin
                dv <= AVS_WRITEDATA_IN[11:8];
            end
        end
    end
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            gap <= 0;
            up_q <= 1'b0;
        end else begin
            gap <= (FIRE_UP_OUT != up_q) ? 0 : gap + 1;
            up_q <= FIRE_UP_OUT;
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);
    AST_WAIT_ONE: assert property (
        (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
        |=> !AVS_WAITREQUEST_OUT) else $error("Late bus answer");
    AST_WAIT_STAND: assert property (
        !AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
        else $error("Answer held too long");
    AST_MEAS_ONE: assert property (MEAS_START_OUT |=> !MEAS_START_OUT)
        else $error("Start pulse too long");
    AST_MEAS_FIRE: assert property (
        ctrl[2] && $past(ctrl[2]) && MEAS_START_OUT |-> ##[0:40]
        ($changed(FIRE_UP_OUT) || $changed(FIRE_DOWN_OUT)))
        else $error("Start without fire");
    AST_IDLE_LOW: assert property (
        ctrl[3] && $past(ctrl[3]) |-> !FIRE_UP_OE_N_OUT && !FIRE_DOWN_OE_N_OUT)
        else $error("Idle pin not driven");
    AST_BOTH_INV: assert property (
        ctrl[1] && UP_ACTIVE_OUT && $changed(FIRE_UP_OUT)
        |-> FIRE_DOWN_OUT == !FIRE_UP_OUT) else $error("Down pin not inverse");
    AST_UP_ONLY: assert property (
        !ctrl[1] && UP_ACTIVE_OUT |-> !FIRE_DOWN_OUT)
        else $error("Down pin moved in up run");
    AST_DIV: assert property (
        UP_ACTIVE_OUT && $past(UP_ACTIVE_OUT) && FIRE_UP_OUT != up_q
        |-> gap >= int'(dv)) else $error("Half pulse too short");
    AST_RETURN: assert property (
        $fell(UP_ACTIVE_OUT) |-> ##[0:2] (!FIRE_UP_OUT
        && (ctrl[3] ? !FIRE_UP_OE_N_OUT : FIRE_UP_OE_N_OUT)))
        else $error("Pin not back at idle");
endmodule // fire_monitor

bind fire_top fire_monitor mon_u (.CLK_IN(CLK_IN), .NRST_IN(NRST_IN),
    .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN),
    .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN),
    .AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN),
    .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .FIRE_UP_OUT(FIRE_UP_OUT),
    .FIRE_UP_OE_N_OUT(FIRE_UP_OE_N_OUT), .FIRE_DOWN_OUT(FIRE_DOWN_OUT),
    .FIRE_DOWN_OE_N_OUT(FIRE_DOWN_OE_N_OUT),
    .MEAS_START_OUT(MEAS_START_OUT), .UP_ACTIVE_OUT(UP_ACTIVE_OUT));

// File: testbench/fire_xducer.sv
module fire_xducer (
    input wire logic clk_in,
    input wire logic [1:0] line_in,
    output int rises_out [2],
    output int high_out [2]
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Counts pulses and last high width
    // ----------------------------------------
    logic [1:0] last = 2'b00;
    int run [2] = '{0, 0};
    initial begin
        rises_out = '{0, 0};
        high_out = '{0, 0};
    end
    always @(posedge clk_in) begin
        for (int i = 0; i < 2; i++) begin
            if (line_in[i] === 1'b1 && last[i] !== 1'b1) begin
                rises_out[i]++;
                run[i] = 1;
            end else if (line_in[i] === 1'b1) begin
                run[i]++;
            end else if (last[i] === 1'b1) begin
                high_out[i] = run[i];
            end
        end
        last = line_in;
    end
endmodule // fire_xducer

// File: testbench/tb_top.sv
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
    failures++; $display("Error at %0t: got %0h, want %0h", $time, \
    got, exp); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int B50 = 20;
    localparam int B60 = 17;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] addr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'hF;
    logic ext_start = 1'b0;
    logic [31:0] rdata;
    logic wait_req, up, up_oe_n, dn, dn_oe_n, meas, up_act, dn_q, act_q;
    int failures = 0, check_count = 0, cyc = 0, dn_last = 0, up_rise = 0;
    int dn_at_up = 0, meas_n = 0, m0, g [4], rises [2], high [2], r0 [2];
    logic [31:0] ctl [4] = '{32'h0201, 32'h0211, 32'h0001, 32'h0000};
    always #20 clk = ~clk;
    fire_top #(.BASE50_CYCLES(B50), .BASE60_CYCLES(B60)) dut_u (
        .CLK_IN(clk), .NRST_IN(nrst), .AVS_ADDRESS_IN(addr),
        .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
        .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata),
        .AVS_WAITREQUEST_OUT(wait_req), .EXT_START_IN(ext_start),
        .FIRE_UP_OUT(up), .FIRE_UP_OE_N_OUT(up_oe_n), .FIRE_DOWN_OUT(dn),
        .FIRE_DOWN_OE_N_OUT(dn_oe_n), .MEAS_START_OUT(meas),
        .UP_ACTIVE_OUT(up_act));
    fire_xducer xd_u (.clk_in(clk), .line_in({dn_oe_n ? 1'b0 : dn,
        up_oe_n ? 1'b0 : up}), .rises_out(rises), .high_out(high));
    always @(posedge clk) begin
        cyc++;
        if (dn !== dn_q) dn_last = cyc;
        if (up_act === 1'b1 && act_q !== 1'b1) begin
            up_rise = cyc;
            dn_at_up = rises[1];
        end
        if (meas === 1'b1) meas_n++;
        dn_q = dn;
        act_q = up_act;
    end
    // ----------------------------------------
    // Bus and run tasks
    // ----------------------------------------
    task automatic bus_rw(input logic w, input logic [3:0] a,
        input logic [31:0] d, input logic [3:0] b, output logic [31:0] q);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        be <= b;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wait_req !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic wr32(input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] b);
        logic [31:0] q;
        bus_rw(1'b1, a, d, b, q);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus_rw(1'b0, a, 32'h0, 4'hF, q);
        `CHK(q, e)
    endtask
    task automatic fire(input logic [31:0] c, input logic [31:0] b,
        input logic [31:0] p, input logic [31:0] cmd);
        logic [31:0] q;
        wr32(fire_pkg::CTRL_ADDR, c, 4'hF);
        wr32(fire_pkg::BURST_ADDR, b, 4'hF);
        wr32(fire_pkg::PHASE_ADDR, p, 4'hF);
        r0 = rises;
        m0 = meas_n;
        wr32(fire_pkg::CMD_ADDR, cmd, 4'hF);
        ext_start <= 1'b1;
        repeat (3) @(posedge clk);
        ext_start <= 1'b0;
        q = 32'h1;
        while (q[0] !== 1'b0) bus_rw(1'b0, fire_pkg::CMD_ADDR, 32'h0, 4'hF, q);
        repeat (4) @(posedge clk);
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #(40 * 40000);
        failures++;
        give_verdict();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(fire_pkg::CTRL_ADDR, fire_pkg::CTRL_RESET);
        rd_chk(fire_pkg::BURST_ADDR, fire_pkg::BURST_RESET);
        rd_chk(fire_pkg::PHASE_ADDR, fire_pkg::PHASE_RESET);
        rd_chk(4'h2, 32'h0);
        `CHK(up_oe_n, 1'b1)
        `CHK(dn_oe_n, 1'b1)
        wr32(fire_pkg::BURST_ADDR, 32'hFFFF_FF03, 4'h1);
        rd_chk(fire_pkg::BURST_ADDR, 32'h0001_0103);
        // Up run, two repeats of three pulses
        fire(32'h0, 32'h0002_0103, 32'h0, 32'h1);
        `CHK(rises[0] - r0[0], 6)
        `CHK(rises[1] - r0[1], 0)
        `CHK(high[0], 2)
        `CHK(meas_n - m0, 1)
        `CHK(up_oe_n, 1'b1)
        // Down run, mixed phases, internal start
        fire(32'h000D, 32'h0001_0205, 32'h0005, 32'h1);
        `CHK(rises[1] - r0[1], 3)
        `CHK(high[1], 3)
        `CHK(rises[0] - r0[0], 0)
        `CHK(meas_n - m0, 1)
        `CHK({up_oe_n, dn_oe_n, dn}, 3'b000)
        // Both pins, sixteen-fold divider
        fire(32'h000A, 32'h0001_0F04, 32'hFFFF, 32'h1);
        `CHK(rises[0] - r0[0], 4)
        `CHK(high[0], 16)
        // Pairs: pause and mains settings, then up first
        for (int i = 0; i < 4; i++) begin
            fire(ctl[i], 32'h0001_0102, 32'h0, 32'h2);
            g[i] = up_rise - dn_last;
            `CHK(dn_at_up - r0[1], (i < 3) ? 2 : 0)
            `CHK(rises[0] - r0[0], 2)
            `CHK(rises[1] - r0[1], 2)
        end
        `CHK(g[0] - g[2], 2 * B50)
        `CHK(g[0] - g[1], 2 * (B50 - B60))
        give_verdict();
    end
endmodule // tb_top
